/* hdl/nibble_sub_pkg.sv */
// Constants, field layouts and register map of the nibble subtract unit
package nibble_sub_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 11;
	localparam int         APB_AW       = 12;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_INSTR    = 12'h000;
	localparam logic [11:0] OFS_STATUS   = 12'h004;
	localparam logic [11:0] OFS_INDEX    = 12'h008;
	localparam logic [11:0] OFS_POINTER  = 12'h00C;
	localparam logic [11:0] OFS_MEM_ADDR = 12'h010;
	localparam logic [11:0] OFS_MEM_DATA = 12'h014;

	// ------------------------------------------------------------
	// Opcodes, arithmetic constants and reset values
	// ------------------------------------------------------------
	localparam logic [4:0] OP_SUB_MI    = 5'h11;
	localparam logic [4:0] OP_SUBTRACT_BORROW_OP_RM   = 5'h03;
	localparam logic [4:0] OP_SUBTRACT_BORROW_OP_MI   = 5'h13;
	localparam logic [3:0] BCD_ADJ      = 4'h6;
	localparam logic [4:0] STATUS_RST   = 5'h00;
	localparam logic [11:0] INDEX_RST   = 12'h000;
	localparam logic [11:0] POINTER_RST = 12'h000;
	localparam logic [15:0] INSTR_RST   = 16'h0000;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] opcode;
		logic [2:0] memory_row_field;
		logic [3:0] memory_column_field;
		logic [3:0] low_field;
	} instr_t;

	typedef struct packed {
		logic index_enable_flag;
		logic bcd_flag;
		logic compare_flag;
		logic zero_flag;
		logic carry_flag;
	} program_status_word_t;

	typedef struct packed {
		logic [3:0] index_high_nibble;
		logic [3:0] index_middle_nibble;
		logic [3:0] index_low_nibble;
	} index_t;

	typedef struct packed {
		logic [3:0] register_pointer_low;
		logic [3:0] register_pointer_high;
		logic [3:0] bank;
	} pointer_t;

endpackage : nibble_sub_pkg

/* hdl/nibble_subtract_unit.sv */
// Nibble subtract datapath with its data memory and an APB register port
//
// Local design decisions: the placing of the registers and register access over APB.
module nibble_subtract_unit (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [nibble_sub_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                       pwdata,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam int AW = nibble_sub_pkg::ADDR_W;

	nibble_sub_pkg::program_status_word_t program_status_word;
	nibble_sub_pkg::index_t               index_q;
	nibble_sub_pkg::pointer_t             pointer_q;
	nibble_sub_pkg::instr_t               instr_q;
	logic [AW-1:0]                        mem_addr_q;
	logic                                 exec_q;
	logic [31:0]                          prdata_q;
	logic                                 pready_q;
	logic                                 pslverr_q;
	logic [3:0]                           mem_q [2**AW];

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire          capture   = psel & penable & ~pready_q;
	wire          access    = psel & penable & pready_q;
	wire          wr        = access & pwrite;
	wire          hit_instr = paddr == nibble_sub_pkg::OFS_INSTR;
	wire          hit_stat  = paddr == nibble_sub_pkg::OFS_STATUS;
	wire          hit_index = paddr == nibble_sub_pkg::OFS_INDEX;
	wire          hit_ptr   = paddr == nibble_sub_pkg::OFS_POINTER;
	wire          hit_maddr = paddr == nibble_sub_pkg::OFS_MEM_ADDR;
	wire          hit_mdata = paddr == nibble_sub_pkg::OFS_MEM_DATA;
	wire          mapped    = hit_instr | hit_stat | hit_index | hit_ptr | hit_maddr | hit_mdata;
	wire [31:0]   rd_word   = hit_instr ? {16'h0000, instr_q} :
	                          hit_stat  ? {27'h000000, program_status_word} :
	                          hit_index ? {20'h00000, index_q} :
	                          hit_ptr   ? {20'h00000, pointer_q} :
	                          hit_maddr ? {21'h00000, mem_addr_q} :
	                          hit_mdata ? {28'h0000000, mem_q[mem_addr_q]} : 32'h00000000;

	// ------------------------------------------------------------
	// Instruction decode and operand addressing
	// ------------------------------------------------------------
	wire          is_sub_mi  = instr_q.opcode == nibble_sub_pkg::OP_SUB_MI;
	wire          is_subtract_borrow_op_rm = instr_q.opcode == nibble_sub_pkg::OP_SUBTRACT_BORROW_OP_RM;
	wire          is_subtract_borrow_op_mi = instr_q.opcode == nibble_sub_pkg::OP_SUBTRACT_BORROW_OP_MI;
	wire          valid_op   = is_sub_mi | is_subtract_borrow_op_rm | is_subtract_borrow_op_mi;
	wire          imm_form   = is_sub_mi | is_subtract_borrow_op_mi;
	wire [AW-1:0] mem_base   = {pointer_q.bank, instr_q.memory_row_field,
	                            instr_q.memory_column_field};
	// Top index nibble carries only three useful bits
	wire [AW-1:0] index_register = {index_q.index_high_nibble[2:0],
	                                index_q.index_middle_nibble,
	                                index_q.index_low_nibble};
	wire [AW-1:0] mem_eff    = program_status_word.index_enable_flag ?
	                           (mem_base | index_register) : mem_base;
	// Row field ignored: register form always lands in the pointer row
	wire [AW-1:0] reg_addr   = {pointer_q.register_pointer_high,
	                            pointer_q.register_pointer_low[2:0],
	                            instr_q.low_field};
	wire [AW-1:0] dest_addr  = imm_form ? mem_eff : reg_addr;

	// ------------------------------------------------------------
	// Arithmetic
	// ------------------------------------------------------------
	wire [3:0]    minuend    = mem_q[dest_addr];
	wire [3:0]    subtrahend = imm_form ? instr_q.low_field : mem_q[mem_eff];
	wire          borrow_in  = (is_subtract_borrow_op_rm | is_subtract_borrow_op_mi)
	                           & program_status_word.carry_flag;
	wire [4:0]    raw_diff   = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, borrow_in};
	wire          borrow     = raw_diff[4];
	// Adjust assumes both operands are valid decimal digits
	wire [3:0]    bcd_diff   = raw_diff[3:0] - nibble_sub_pkg::BCD_ADJ;
	wire [3:0]    result     = (program_status_word.bcd_flag && borrow) ?
	                           bcd_diff : raw_diff[3:0];
	wire          res_zero   = result == 4'h0;
	wire          zero_next  = !res_zero ? 1'b0 :
	                           program_status_word.compare_flag ?
	                           program_status_word.zero_flag :
	                           1'b1;
	wire          do_exec    = exec_q & valid_op;
	wire          do_store   = do_exec & ~program_status_word.compare_flag;

	// ------------------------------------------------------------
	// Data memory
	// ------------------------------------------------------------
	// Not reset: contents are software data, not control state
	always_ff @(posedge pclk) begin
		if (do_store) begin
			mem_q[dest_addr] <= result;
		end else if (wr && hit_mdata) begin
			mem_q[mem_addr_q] <= pwdata[3:0];
		end
	end

	// ------------------------------------------------------------
	// Program status word
	// ------------------------------------------------------------
	// Hardware update wins over a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_status_word <= nibble_sub_pkg::STATUS_RST;
		end else if (do_exec) begin
			program_status_word.carry_flag <= borrow;
			program_status_word.zero_flag  <= zero_next;
		end else if (wr && hit_stat) begin
			program_status_word <= pwdata[4:0];
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_q    <= nibble_sub_pkg::INDEX_RST;
			pointer_q  <= nibble_sub_pkg::POINTER_RST;
			instr_q    <= nibble_sub_pkg::INSTR_RST;
			mem_addr_q <= '0;
			exec_q     <= 1'b0;
		end else begin
			exec_q <= wr & hit_instr;
			if (wr && hit_index) begin
				index_q <= pwdata[11:0];
			end
			if (wr && hit_ptr) begin
				pointer_q <= pwdata[11:0];
			end
			if (wr && hit_instr) begin
				instr_q <= pwdata[15:0];
			end
			if (wr && hit_maddr) begin
				mem_addr_q <= pwdata[AW-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// APB answer
	// ------------------------------------------------------------
	// One wait state keeps read data clear of the execute cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= capture;
			pslverr_q <= capture & ~mapped;
			if (capture) begin
				prdata_q <= rd_word;
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_reg_row;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && is_subtract_borrow_op_rm) |->
		dest_addr == {pointer_q.register_pointer_high,
		              pointer_q.register_pointer_low[2:0], instr_q[3:0]};
	endproperty
	a_reg_row: assert property (p_reg_row)
		else $error("register operand outside pointer row");

	property p_cmp_hold;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && program_status_word.compare_flag) |=>
		mem_q[$past(dest_addr)] == $past(minuend);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold)
		else $error("destination changed in compare mode");

	property p_decode_imm;
		@(posedge pclk) disable iff (!presetn)
		(exec_q && instr_q[15:11] == 5'h11) |->
		(dest_addr == mem_eff && subtrahend == instr_q[3:0] && !borrow_in);
	endproperty
	a_decode_imm: assert property (p_decode_imm)
		else $error("immediate subtract decoded wrongly");

	property p_store_bin;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && !program_status_word.compare_flag && !program_status_word.bcd_flag) |=>
		mem_q[$past(dest_addr)] == $past(raw_diff[3:0]);
	endproperty
	a_store_bin: assert property (p_store_bin)
		else $error("binary difference not stored");

	property p_carry;
		@(posedge pclk) disable iff (!presetn)
		do_exec |=> program_status_word.carry_flag == $past(raw_diff[4]);
	endproperty
	a_carry: assert property (p_carry)
		else $error("carry does not follow borrow");

	property p_zero_clear;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && result != 4'h0) |=> !program_status_word.zero_flag;
	endproperty
	a_zero_clear: assert property (p_zero_clear)
		else $error("zero kept on nonzero difference");

	property p_zero_set;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && result == 4'h0 && !program_status_word.compare_flag) |=>
		program_status_word.zero_flag;
	endproperty
	a_zero_set: assert property (p_zero_set)
		else $error("zero not set on zero difference");

	property p_zero_keep;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && result == 4'h0 && program_status_word.compare_flag) |=>
		$stable(program_status_word.zero_flag);
	endproperty
	a_zero_keep: assert property (p_zero_keep)
		else $error("zero changed in compare of equal nibbles");

	property p_bcd;
		@(posedge pclk) disable iff (!presetn)
		(do_store && program_status_word.bcd_flag && raw_diff[4]) |=>
		mem_q[$past(dest_addr)] == $past(bcd_diff);
	endproperty
	a_bcd: assert property (p_bcd)
		else $error("decimal adjust missing");

	property p_chain;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && instr_q[15:11] != 5'h11) |->
		raw_diff == {1'b0, minuend} - {1'b0, subtrahend}
		            - {4'h0, program_status_word.carry_flag};
	endproperty
	a_chain: assert property (p_chain)
		else $error("borrow form ignores incoming carry");

	property p_index;
		@(posedge pclk) disable iff (!presetn)
		(exec_q && program_status_word.index_enable_flag) |->
		mem_eff == (mem_base | {index_q[10:8], index_q[7:4], index_q[3:0]});
	endproperty
	a_index: assert property (p_index)
		else $error("index not ORed into address");

	property p_subtract_borrow_op_rm_cmp;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && is_subtract_borrow_op_rm && program_status_word.compare_flag) |=>
		(mem_q[$past(reg_addr)] == $past(minuend)
		 && program_status_word.carry_flag == $past(borrow));
	endproperty
	a_subtract_borrow_op_rm_cmp: assert property (p_subtract_borrow_op_rm_cmp)
		else $error("compare of register form misbehaves");

	property p_bcd_plain;
		@(posedge pclk) disable iff (!presetn)
		(do_store && program_status_word.bcd_flag && !raw_diff[4]) |=>
		mem_q[$past(dest_addr)] == $past(raw_diff[3:0]);
	endproperty
	a_bcd_plain: assert property (p_bcd_plain)
		else $error("decimal result adjusted without borrow");

	property p_reg_store;
		@(posedge pclk) disable iff (!presetn)
		(do_store && is_subtract_borrow_op_rm && !program_status_word.bcd_flag) |=>
		mem_q[$past(reg_addr)] ==
		$past(minuend - subtrahend - {3'h0, program_status_word.carry_flag});
	endproperty
	a_reg_store: assert property (p_reg_store)
		else $error("register form result not stored");

	property p_subtract_borrow_op_imm;
		@(posedge pclk) disable iff (!presetn)
		(do_exec && is_subtract_borrow_op_mi) |->
		(dest_addr == mem_eff && subtrahend == instr_q[3:0]
		 && borrow_in == program_status_word.carry_flag);
	endproperty
	a_subtract_borrow_op_imm: assert property (p_subtract_borrow_op_imm)
		else $error("immediate borrow form decoded wrongly");

	property p_bad_op;
		@(posedge pclk) disable iff (!presetn)
		(exec_q && !valid_op) |=> $stable(program_status_word);
	endproperty
	a_bad_op: assert property (p_bad_op)
		else $error("unknown opcode changed the flags");

	property p_index_off;
		@(posedge pclk) disable iff (!presetn)
		(exec_q && !program_status_word.index_enable_flag) |-> mem_eff == mem_base;
	endproperty
	a_index_off: assert property (p_index_off)
		else $error("index applied while disabled");

endmodule : nibble_subtract_unit

/* verification/apb_host.sv */
// APB master model standing in for the software side of the subtract unit
module apb_host (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// ------------------------------------------------------------
	// One transfer
	// ------------------------------------------------------------
	// Idles a cycle after each transfer, so psel is never set twice in one step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			nibble_subtract_unit_test.miscompares++;
			$display("mismatch pready expected 1 seen %b", pready);
			nibble_subtract_unit_test.tally_and_finish();
		end
	endtask : xfer
endmodule : apb_host

/* verification/nibble_subtract_unit_test.sv */
// Self-checking bench for the nibble subtract unit
module nibble_subtract_unit_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Clock, reset and wiring
	// ------------------------------------------------------------
	localparam logic [4:0] sub_mi  = nibble_sub_pkg::OP_SUB_MI;
	localparam logic [4:0] subtract_borrow_op_mi = nibble_sub_pkg::OP_SUBTRACT_BORROW_OP_MI;
	localparam logic [4:0] subtract_borrow_op_rm = nibble_sub_pkg::OP_SUBTRACT_BORROW_OP_RM;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int          miscompares = 0;
	int          checked = 0;

	always #12.5 pclk = ~pclk;

	nibble_subtract_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// Operations
	// ------------------------------------------------------------
	task automatic setm(input logic [10:0] a, input logic [3:0] v);
		host.xfer(1'b1, nibble_sub_pkg::OFS_MEM_ADDR, {21'h00000, a}, q, e);
		host.xfer(1'b1, nibble_sub_pkg::OFS_MEM_DATA, {28'h0000000, v}, q, e);
	endtask : setm

	// Memory is not reset, so only nibbles seeded here are ever read back
	task automatic run_op(input logic [4:0] op, input logic [10:0] fld, input logic [4:0] st,
		input logic [10:0] dst, input logic [3:0] dv, input logic [10:0] src,
		input logic [3:0] sv, input logic [3:0] res, input logic [4:0] res_st);
		setm(dst, dv);
		if (src != dst)
			setm(src, sv);
		host.xfer(1'b1, nibble_sub_pkg::OFS_STATUS, {27'h000000, st}, q, e);
		host.xfer(1'b1, nibble_sub_pkg::OFS_INSTR, {16'h0000, op, fld}, q, e);
		host.xfer(1'b0, nibble_sub_pkg::OFS_STATUS, 32'h00000000, q, e);
		chk("status flags", {27'h000000, res_st}, q);
		host.xfer(1'b1, nibble_sub_pkg::OFS_MEM_ADDR, {21'h00000, dst}, q, e);
		host.xfer(1'b0, nibble_sub_pkg::OFS_MEM_DATA, 32'h00000000, q, e);
		chk("result nibble", {28'h0000000, res}, q);
	endtask : run_op

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			host.xfer(1'b0, 12'(4 * i), 32'h00000000, q, e);
			chk("reset value", 32'h00000000, q);
		end
		host.xfer(1'b0, 12'h018, 32'h00000000, q, e);
		chk("unmapped error", 32'h00000001, {31'h0000000, e});
		chk("unmapped data", 32'h00000000, q);
		// Immediate forms, binary, pointer and index clear
		run_op(sub_mi, 11'h2F5, 5'h00, 11'h02F, 4'h9, 11'h02F, 4'h0, 4'h4, 5'h00);
		run_op(sub_mi, 11'h2F5, 5'h00, 11'h02F, 4'h3, 11'h02F, 4'h0, 4'hE, 5'h01);
		run_op(sub_mi, 11'h2F5, 5'h00, 11'h02F, 4'h5, 11'h02F, 4'h0, 4'h0, 5'h02);
		run_op(sub_mi, 11'h2F5, 5'h06, 11'h02F, 4'h5, 11'h02F, 4'h0, 4'h5, 5'h06);
		run_op(sub_mi, 11'h2F5, 5'h04, 11'h02F, 4'h5, 11'h02F, 4'h0, 4'h5, 5'h04);
		run_op(sub_mi, 11'h2F5, 5'h06, 11'h02F, 4'h7, 11'h02F, 4'h0, 4'h7, 5'h04);
		run_op(subtract_borrow_op_mi, 11'h2F2, 5'h01, 11'h02F, 4'h5, 11'h02F, 4'h0, 4'h2, 5'h00);
		run_op(subtract_borrow_op_mi, 11'h2F0, 5'h01, 11'h02F, 4'h0, 11'h02F, 4'h0, 4'hF, 5'h01);
		run_op(subtract_borrow_op_mi, 11'h2F0, 5'h07, 11'h02F, 4'h1, 11'h02F, 4'h0, 4'h1, 5'h06);
		// Decimal mode subtracts six more on a borrow
		run_op(sub_mi, 11'h2F5, 5'h08, 11'h02F, 4'h3, 11'h02F, 4'h0, 4'h8, 5'h09);
		run_op(subtract_borrow_op_mi, 11'h2F0, 5'h09, 11'h02F, 4'h0, 11'h02F, 4'h0, 4'h9, 5'h09);
		run_op(sub_mi, 11'h2F4, 5'h08, 11'h02F, 4'h9, 11'h02F, 4'h0, 4'h5, 5'h08);
		// Unknown opcode leaves memory and flags alone
		run_op(5'h00, 11'h2F5, 5'h01, 11'h02F, 4'h9, 11'h02F, 4'h0, 4'h9, 5'h01);
		// Register form: row 0 of bank 0 holds the registers
		run_op(subtract_borrow_op_rm, 11'h2DD, 5'h01, 11'h00D, 4'h3, 11'h02D, 4'h1, 4'h1, 5'h00);
		run_op(subtract_borrow_op_rm, 11'h2DD, 5'h05, 11'h00D, 4'h1, 11'h02D, 4'h1, 4'h1, 5'h05);
		run_op(subtract_borrow_op_rm, 11'h2DD, 5'h00, 11'h00D, 4'h4, 11'h02D, 4'h4, 4'h0, 5'h02);
		run_op(subtract_borrow_op_rm, 11'h2DD, 5'h01, 11'h00D, 4'h2, 11'h02D, 4'h4, 4'hD, 5'h01);
		// Pointer row 1: the register comes from it, not from the row field
		host.xfer(1'b1, nibble_sub_pkg::OFS_POINTER, 32'h00000100, q, e);
		run_op(subtract_borrow_op_rm, 11'h5F3, 5'h00, 11'h013, 4'h8, 11'h05F, 4'h3, 4'h5, 5'h00);
		// Index 0x140 is ORed into the memory operand only
		host.xfer(1'b1, nibble_sub_pkg::OFS_INDEX, 32'h00000140, q, e);
		run_op(sub_mi, 11'h2F5, 5'h10, 11'h16F, 4'h9, 11'h16F, 4'h0, 4'h4, 5'h10);
		run_op(subtract_borrow_op_rm, 11'h2D3, 5'h10, 11'h013, 4'h9, 11'h16D, 4'h2, 4'h7, 5'h10);
		run_op(sub_mi, 11'h2F5, 5'h00, 11'h02F, 4'h6, 11'h02F, 4'h0, 4'h1, 5'h00);
		tally_and_finish();
	end
endmodule : nibble_subtract_unit_test
